// ### core/edge_sync.sv
// Two-flop synchroniser for an outside clock pin, followed by a rising edge detector.
// Assumes the pin is asynchronous to pclk and slower than half its rate.
`timescale 1ns/1ps
module edge_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and result
  input  wire logic pin,
  output logic      rise
);

  logic meta;
  logic stable;
  logic last;

  ////////////////////////////////////////////////////////////////////////////////
  // The first flop feeds only the second; the detector looks at the settled pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
    end
  end

  // One-cycle pulse on each low-to-high change.
  assign rise = stable & ~last;

endmodule

// ### core/prescaler.sv
// Input prescaler of the timer: passes one tick in 1, 2, 4 or 8.
// Assumes tick_in is a one-cycle pulse on pclk; clear has priority over counting.
`timescale 1ns/1ps
module prescaler
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] select,
  // Ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [2:0] steps;
  wire  [2:0] mask = prescale_mask(select);

  ////////////////////////////////////////////////////////////////////////////////
  // A tick passes when all selected low bits are set, so 00 passes every tick.
  assign tick_out = tick_in & ((steps & mask) == mask);

  // Free running divider; a change of ratio on the fly only shifts the phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steps <= 3'h0;
    end else if (clear) begin
      steps <= 3'h0;
    end else if (tick_in) begin
      steps <= steps + 3'h1;
    end
  end

endmodule

// ### core/timer_counter.sv
// Sixteen-bit up timer/counter with prescaler, buffered wide access and oscillator control.
// Assumes an APB master on pclk, the count pin on an outside clock, and a compare unit on pclk.
//
// How it works
// - Wide mode makes count access one 16-bit operation.
// - Status bit shows system clock from our oscillator.
// - Prescale codes divide by 1, 2, 4, 8.
// - Oscillator enable bit powers the crystal amplifier.
// - Bypass bit skips edge alignment, external source only.
// - Source bit picks quarter clock or pin edges.
// - Counter-on bit gates counting, otherwise count holds.
// - While on, both pins forced input, read zero.
// - Wide mode: low read copies high into buffer.
// - Wide mode: high write buffers, low write commits.
// - Low write clears prescaler, high write does not.
// - Oscillator keeps running through all power modes.
// - Clock select 01 runs system from our oscillator.
// - Sleep in secondary run, idle bit clear: idle.
// - Count wraps FFFF to 0000 and sets flag.
// - Interrupt request only when enable bit set.
// - Special compare trigger zeroes count unless asynchronous.
// - Software write beats a coinciding trigger reset.
// - Trigger reset never sets the overflow flag.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module timer_counter
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Count pin (external clock or oscillator output)
  input  wire logic        ext_clock_pin,
  // Pin and oscillator control
  output logic             osc_amp_enable,
  output logic             pins_force_input,
  output logic             port_pins_read_zero,
  // Compare unit
  input  wire logic [3:0]  compare_mode_select,
  input  wire logic        compare_match,
  // Power management
  input  wire logic        sleep_exec,
  input  wire logic        wake_event,
  output logic             osc_clock_status,
  output logic             secondary_idle,
  output logic             full_sleep,
  // Interrupt request
  output logic             timer_irq
);

  logic [7:0]   timer_one_control;
  logic [15:0]  count;
  logic [7:0]   count_high_buffer;
  logic         overflow_flag;
  logic         overflow_irq_enable;
  logic [1:0]   system_clock_select;
  logic         idle_on_sleep;
  logic         ack;
  logic [1:0]   phase;
  logic         edge_pending;
  power_state_t power_state;
  power_state_t next_power_state;
  logic [15:0]  next_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields.
  wire       wide_access_enable = timer_one_control[BIT_WIDE];
  wire [1:0] input_prescale_select = timer_one_control[BIT_PS_HI:BIT_PS_LO];
  wire       osc_enable = timer_one_control[BIT_OSC_EN];
  wire       sync_bypass = timer_one_control[BIT_SYNC_BYP];
  wire       clock_source_select = timer_one_control[BIT_SRC];
  wire       counter_on = timer_one_control[BIT_ON];

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode. One wait state lets prdata come from a flop and keeps side effects on one edge.
  wire access  = psel & penable & ~ack;
  wire do_wr   = access & pwrite;
  wire do_rd   = access & ~pwrite;
  wire sel_ctl = hits(paddr, ADDR_CONTROL);
  wire sel_lo  = hits(paddr, ADDR_COUNT_LOW);
  wire sel_hi  = hits(paddr, ADDR_COUNT_HIGH);
  wire sel_flg = hits(paddr, ADDR_FLAG);
  wire sel_ien = hits(paddr, ADDR_IRQ_ENABLE);
  wire sel_osc = hits(paddr, ADDR_OSC_CONTROL);
  wire mapped  = sel_ctl | sel_lo | sel_hi | sel_flg | sel_ien | sel_osc;
  wire wr_low  = do_wr & sel_lo;
  wire wr_high = do_wr & sel_hi;
  wire rd_low  = do_rd & sel_lo;
  wire count_write = wr_low | (wr_high & ~wide_access_enable);

  assign pready  = ack;
  assign pslverr = ack & ~mapped;

  // Bus handshake flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= 1'b0;
    end else begin
      ack <= access;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Count sources: instruction tick at a quarter of pclk, or synchronised pin edges.
  logic ext_rise;

  edge_sync u_edge_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_clock_pin),
    .rise    (ext_rise)
  );

  wire instr_tick = (phase == PHASE_LAST);
  wire aligned_tick = instr_tick & (edge_pending | ext_rise);
  wire ext_tick = sync_bypass ? ext_rise : aligned_tick;
  wire src_tick = clock_source_select ? ext_tick : instr_tick;
  wire is_async = clock_source_select & sync_bypass;

  // Quarter-rate phase and the pending edge that waits for the next instruction cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase        <= 2'h0;
      edge_pending <= 1'b0;
    end else begin
      phase        <= phase + PHASE_STEP;
      edge_pending <= instr_tick ? 1'b0 : (edge_pending | ext_rise);
    end
  end

  logic scaled_tick;

  prescaler u_prescaler (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (wr_low),
    .select   (input_prescale_select),
    .tick_in  (src_tick),
    .tick_out (scaled_tick)
  );

  wire count_tick = counter_on & scaled_tick;
  wire trigger_ok = compare_match & (compare_mode_select == COMPARE_SPECIAL) & ~is_async;
  wire overflow_evt = count_tick & ~count_write & ~trigger_ok & (count == COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////////
  // Next count: software write first, then trigger reset, then increment with wrap.
  always_comb begin
    next_count = count;
    if (wr_low) begin
      next_count = {wide_access_enable ? count_high_buffer : count[15:8], pwdata[7:0]};
    end else if (wr_high && !wide_access_enable) begin
      next_count = {pwdata[7:0], count[7:0]};
    end else if (trigger_ok) begin
      next_count = COUNT_ZERO;
    end else if (count_tick) begin
      next_count = count + COUNT_ONE;
    end
  end

  // Counter and high byte buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count             <= COUNT_ZERO;
      count_high_buffer <= 8'h00;
    end else begin
      count <= next_count;
      if (wr_high && wide_access_enable) begin
        count_high_buffer <= pwdata[7:0];
      end else if (rd_low && wide_access_enable) begin
        count_high_buffer <= count[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers. A set from overflow wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_one_control   <= CONTROL_RESET;
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      system_clock_select <= SCS_RESET;
      idle_on_sleep       <= 1'b0;
    end else begin
      if (do_wr && sel_ctl) begin
        timer_one_control <= pwdata[7:0] & CONTROL_WRITE_MASK;
      end
      overflow_flag <= overflow_evt | ((do_wr && sel_flg) ? pwdata[BIT_FLAG] : overflow_flag);
      if (do_wr && sel_ien) begin
        overflow_irq_enable <= pwdata[BIT_FLAG];
      end
      if (do_wr && sel_osc) begin
        system_clock_select <= pwdata[1:0];
        idle_on_sleep       <= pwdata[BIT_IDLE_ON_SLEEP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, captured on the access edge so the buffer copy and the returned low byte agree.
  wire [7:0] ctl_view = {timer_one_control[7], osc_clock_status, timer_one_control[5:0]};
  wire [7:0] hi_view = wide_access_enable ? count_high_buffer : count[15:8];
  wire [7:0] osc_view = {idle_on_sleep, 5'h00, system_clock_select};
  wire [7:0] read_byte = sel_ctl ? ctl_view :
                         sel_lo  ? count[7:0] :
                         sel_hi  ? hi_view :
                         sel_flg ? {7'h00, overflow_flag} :
                         sel_ien ? {7'h00, overflow_irq_enable} :
                         sel_osc ? osc_view : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (do_rd) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-managed state. Entering idle from secondary run keeps our oscillator as the clock.
  always_comb begin
    next_power_state = power_state;
    case (power_state)
      PM_RUN: begin
        if (sleep_exec) begin
          if (system_clock_select == SCS_SECONDARY && !idle_on_sleep) begin
            next_power_state = PM_SEC_IDLE;
          end else begin
            next_power_state = PM_SLEEP;
          end
        end
      end
      PM_SEC_IDLE: begin
        if (wake_event) begin
          next_power_state = PM_RUN;
        end
      end
      PM_SLEEP: begin
        if (wake_event) begin
          next_power_state = PM_RUN;
        end
      end
      default: begin
        next_power_state = PM_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state <= PM_RUN;
    end else begin
      power_state <= next_power_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin, oscillator and status outputs. The amplifier ignores power state so it never stops in sleep.
  assign osc_amp_enable      = osc_enable;
  assign pins_force_input    = counter_on;
  assign port_pins_read_zero = counter_on;
  assign osc_clock_status    = (system_clock_select == SCS_SECONDARY);
  assign secondary_idle      = (power_state == PM_SEC_IDLE);
  assign full_sleep          = (power_state == PM_SLEEP);
  assign timer_irq           = overflow_flag & overflow_irq_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_write_beats_trigger: assert property (wr_low && trigger_ok |=> count[7:0] == $past(pwdata[7:0]))
    else $error("Trigger reset overrode a software write.");
  a_trigger_zeroes: assert property (trigger_ok && !count_write |=> count == COUNT_ZERO)
    else $error("Trigger did not zero the count.");
  a_trigger_no_flag: assert property (trigger_ok && !count_write && !overflow_flag && !(do_wr && sel_flg)
                                      |=> !overflow_flag)
    else $error("Trigger reset set the overflow flag.");
  a_wrap_sets_flag: assert property (count_tick && count == COUNT_MAX && !count_write && !trigger_ok
                                     |=> overflow_flag && count == COUNT_ZERO)
    else $error("Wrap did not clear count and set flag.");
  a_irq_masked: assert property (!overflow_irq_enable && overflow_flag |-> !timer_irq)
    else $error("Masked overflow raised an interrupt.");
  a_hold_when_off: assert property (!counter_on && !count_write && !trigger_ok |=> $stable(count))
    else $error("Count moved while stopped.");
  a_wide_buffer_load: assert property (rd_low && wide_access_enable |=> count_high_buffer == $past(count[15:8]))
    else $error("Low read did not copy the high byte.");
  a_wide_commit: assert property (wr_low && wide_access_enable |=> count[15:8] == $past(count_high_buffer))
    else $error("Low write did not commit the buffered high byte.");
  a_instr_rate: assert property (count_tick && !clock_source_select |-> $past(phase, 1) == 2'h2)
    else $error("Internal count not on the quarter-rate tick.");
  a_sec_idle_entry: assert property (power_state == PM_RUN && sleep_exec && osc_clock_status && !idle_on_sleep
                                     |=> secondary_idle)
    else $error("Sleep did not enter secondary idle.");

  c_wrap: cover property (overflow_evt);
  c_trigger_reset: cover property (trigger_ok && count != COUNT_ZERO);
  c_wide_read: cover property (rd_low && wide_access_enable);
  c_sync_ext_count: cover property (count_tick && clock_source_select && !sync_bypass);

endmodule

// ### core/timer_pkg.sv
// Shared constants for the sixteen-bit timer/counter: register map, field positions and helpers.
// Assumes an APB slave with 32-bit data, one aligned word per register, byte addresses in paddr.
package timer_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL     = 8'h00;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h04;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_FLAG        = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h10;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'h14;

  // Field positions in timer_one_control.
  localparam int BIT_WIDE      = 7;
  localparam int BIT_STATUS    = 6;
  localparam int BIT_PS_HI     = 5;
  localparam int BIT_PS_LO     = 4;
  localparam int BIT_OSC_EN    = 3;
  localparam int BIT_SYNC_BYP  = 2;
  localparam int BIT_SRC       = 1;
  localparam int BIT_ON        = 0;

  // Field positions in the oscillator control and flag registers.
  localparam int BIT_IDLE_ON_SLEEP = 7;
  localparam int BIT_FLAG          = 0;

  // Reset values and masks.
  localparam logic [7:0]  CONTROL_RESET      = 8'h00;
  localparam logic [7:0]  CONTROL_WRITE_MASK = 8'hBF;
  localparam logic [1:0]  SCS_RESET          = 2'h0;
  localparam logic [1:0]  SCS_SECONDARY      = 2'h1;
  localparam logic [3:0]  COMPARE_SPECIAL    = 4'hB;
  localparam logic [15:0] COUNT_ZERO         = 16'h0000;
  localparam logic [15:0] COUNT_MAX          = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE          = 16'h0001;

  // Instruction clock runs at a quarter of pclk.
  localparam logic [1:0]  PHASE_LAST = 2'h3;
  localparam logic [1:0]  PHASE_STEP = 2'h1;

  // Power-managed states as seen from this block.
  typedef enum logic [1:0] {PM_RUN, PM_SEC_IDLE, PM_SLEEP} power_state_t;

  // Prescale code to the mask of counter bits that must all be set to pass a tick.
  function automatic logic [2:0] prescale_mask(input logic [1:0] code);
    case (code)
      2'h3:    prescale_mask = 3'h7;
      2'h2:    prescale_mask = 3'h3;
      2'h1:    prescale_mask = 3'h1;
      default: prescale_mask = 3'h0;
    endcase
  endfunction

  // Address match helper, used by every register decode.
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] reg_addr);
    hits = (addr == reg_addr);
  endfunction

endpackage

// ### tb/clock_source_model.sv
// Far-side model: a low-power crystal that drives the count pin of the timer.
// Assumes the bench asks for bursts of edges; the pin stands low between bursts.
`timescale 1ns/1ps
module clock_source_model #(
  parameter int HALF_NS = 162
) (
  // Amplifier control from the timer
  input  wire logic osc_amp_enable,
  // Count pin
  output logic      pin
);
  ////////////////////////////////////////////////////////////////////////////////
  // The pin rests low outside a burst, so no stale edge can reach the counter.
  initial begin
    pin = 1'b0;
  end

  // One burst of rising edges; power modes are not looked at, so bursts go on in sleep too.
  task automatic send_edges(input int n);
    for (int i = 0; i < n; i++) begin
      #(HALF_NS);
      // A crystal whose amplifier is off cannot swing at all.
      if (osc_amp_enable === 1'b1) begin
        pin = 1'b1;
      end
      #(HALF_NS);
      pin = 1'b0;
    end
  endtask
endmodule

// ### tb/timer_counter_tb.sv
// Self-checking bench for the timer/counter: APB register tasks and directed sequences.
// Assumes the crystal model in clock_source_model and the register map in timer_pkg.
`timescale 1ns/1ps
module timer_counter_tb;
  import timer_pkg::*;
  // Bus, pins and bench state
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, held;
  logic        pin, osc_en, force_in, read_zero, cmatch, sleep_exec, wake_event;
  logic        osc_stat, sec_idle, full_sleep, irq;
  logic [3:0]  cmode;
  int          bad_count, total_checks;
  localparam int STARTUP = 40;

  ////////////////////////////////////////////////////////////////////////////////
  timer_counter i_timer_counter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin(pin), .osc_amp_enable(osc_en), .pins_force_input(force_in),
    .port_pins_read_zero(read_zero), .compare_mode_select(cmode), .compare_match(cmatch),
    .sleep_exec(sleep_exec), .wake_event(wake_event), .osc_clock_status(osc_stat),
    .secondary_idle(sec_idle), .full_sleep(full_sleep), .timer_irq(irq));

  clock_source_model #(.HALF_NS(162)) i_clock_source_model (.osc_amp_enable(osc_en), .pin(pin));

  // Free-running bus clock, 25 ns period.
  initial begin
    pclk = 1'b0;
  end
  always #12.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Counting and reporting; case inequality keeps an unknown from passing.
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input logic [31:0] lo, hi, got);
    total_checks++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      bad_count++;
      $display("[ERR] %s expected %h to %h seen %h", what, lo, hi, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One APB transfer; trig raises a compare trigger at the very edge the transfer is taken.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic trig);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    cmatch  <= trig;
    do begin
      @(posedge pclk);
      cmatch <= 1'b0;
      n++;
    end while (pready !== 1'b1 && n < 16);
    // A slave that never answers ends the run at once, through the common closing task.
    if (n >= 16) begin
      bad_count++;
      $display("[ERR] pready expected 1 seen %b", pready);
      report_and_stop();
    end
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    check_val(what, exp, rd);
  endtask

  // One-cycle pulse: 0 sleep, 1 wake, 2 compare trigger; waits for the result to land.
  task automatic strobe(input int which);
    @(posedge pclk);
    sleep_exec <= (which == 0);
    wake_event <= (which == 1);
    cmatch     <= (which == 2);
    @(posedge pclk);
    sleep_exec <= 1'b0;
    wake_event <= 1'b0;
    cmatch     <= 1'b0;
    #1;
  endtask

  // Preset a count byte, set control, let the crystal settle, send edges, read the low byte.
  task automatic ext_run(input logic [7:0] ctl, a, input int edges, input logic [31:0] exp);
    wr(a, 32'h0);
    wr(ADDR_CONTROL, {24'h0, ctl});
    repeat (STARTUP) @(posedge pclk);
    i_clock_source_model.send_edges(edges);
    repeat (24) @(posedge pclk);
    rdc("ext count", ADDR_COUNT_LOW, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard: the sequences need well under a fifth of this span.
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, cmatch, sleep_exec, wake_event} = 7'h00;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    cmode        = 4'h0;
    bad_count    = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("control reset", ADDR_CONTROL, {24'h0, CONTROL_RESET});
    rdc("flag reset", ADDR_FLAG, 32'h0);
    apb(1'b0, 8'h40, 32'h0, 1'b0);
    check_val("unmapped data", 32'h0, rd);
    check_val("unmapped err", 32'h1, {31'h0, rerr});
    wr(ADDR_CONTROL, 32'hFF);
    rdc("control bits", ADDR_CONTROL, {24'h0, CONTROL_WRITE_MASK});
    check_val("osc amp on", 32'h1, {31'h0, osc_en});
    check_val("pins input", 32'h1, {31'h0, force_in});
    check_val("pins zero", 32'h1, {31'h0, read_zero});
    wr(ADDR_CONTROL, 32'h0);
    check_val("osc amp off", 32'h0, {31'h0, osc_en});
    check_val("pins free", 32'h0, {31'h0, force_in});
    // Power modes driven from the oscillator control register.
    wr(ADDR_OSC_CONTROL, {30'h0, SCS_SECONDARY});
    check_val("clock status", 32'h1, {31'h0, osc_stat});
    rdc("status bit", ADDR_CONTROL, 32'h40);
    strobe(0);
    check_val("sec idle", 32'h1, {31'h0, sec_idle});
    check_val("not asleep", 32'h0, {31'h0, full_sleep});
    strobe(1);
    check_val("woken", 32'h0, {31'h0, sec_idle});
    wr(ADDR_OSC_CONTROL, 32'h81);
    strobe(0);
    check_val("full sleep", 32'h1, {31'h0, full_sleep});
    strobe(1);
    wr(ADDR_OSC_CONTROL, 32'h0);
    rdc("status clear", ADDR_CONTROL, 32'h0);
    // Wide access through the high-byte buffer.
    wr(ADDR_CONTROL, 32'h80);
    wr(ADDR_COUNT_HIGH, 32'h12);
    wr(ADDR_COUNT_LOW, 32'h34);
    rdc("wide low", ADDR_COUNT_LOW, 32'h34);
    rdc("wide high", ADDR_COUNT_HIGH, 32'h12);
    wr(ADDR_COUNT_HIGH, 32'h56);
    rdc("low again", ADDR_COUNT_LOW, 32'h34);
    rdc("high live", ADDR_COUNT_HIGH, 32'h12);
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_COUNT_HIGH, 32'h77);
    rdc("byte high", ADDR_COUNT_HIGH, 32'h77);
    // Compare trigger: reset, write priority, other mode, asynchronous counter.
    wr(ADDR_CONTROL, 32'h80);
    wr(ADDR_COUNT_HIGH, 32'h12);
    wr(ADDR_COUNT_LOW, 32'h34);
    cmode <= COMPARE_SPECIAL;
    strobe(2);
    rdc("trig low", ADDR_COUNT_LOW, 32'h0);
    rdc("trig high", ADDR_COUNT_HIGH, 32'h0);
    rdc("trig flag", ADDR_FLAG, 32'h0);
    wr(ADDR_COUNT_HIGH, 32'h12);
    apb(1'b1, ADDR_COUNT_LOW, 32'h34, 1'b1);
    rdc("write wins", ADDR_COUNT_LOW, 32'h34);
    rdc("write wins hi", ADDR_COUNT_HIGH, 32'h12);
    cmode <= 4'h3;
    strobe(2);
    rdc("other mode", ADDR_COUNT_LOW, 32'h34);
    wr(ADDR_CONTROL, 32'h86);
    cmode <= COMPARE_SPECIAL;
    strobe(2);
    rdc("async kept", ADDR_COUNT_LOW, 32'h34);
    // Timer mode at every prescale code, then a stopped count must hold.
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_COUNT_HIGH, 32'h0);
      wr(ADDR_COUNT_LOW, 32'h0);
      wr(ADDR_CONTROL, {26'h0, c[1:0], 4'h1});
      repeat ((128 << c) - 4) @(posedge pclk);
      wr(ADDR_CONTROL, 32'h0);
      apb(1'b0, ADDR_COUNT_LOW, 32'h0, 1'b0);
      check_range("timer count", 32'd31, 32'd33, rd);
      held = rd;
      repeat (40) @(posedge pclk);
      rdc("held count", ADDR_COUNT_LOW, held);
    end
    // Overflow, flag latch and interrupt masking.
    wr(ADDR_CONTROL, 32'h80);
    wr(ADDR_COUNT_HIGH, 32'hFF);
    wr(ADDR_COUNT_LOW, 32'hFE);
    wr(ADDR_CONTROL, 32'h81);
    repeat (20) @(posedge pclk);
    wr(ADDR_CONTROL, 32'h80);
    rdc("wrap flag", ADDR_FLAG, 32'h1);
    check_val("masked irq", 32'h0, {31'h0, irq});
    apb(1'b0, ADDR_COUNT_LOW, 32'h0, 1'b0);
    check_range("wrap low", 32'h0, 32'h8, rd);
    rdc("wrap high", ADDR_COUNT_HIGH, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    check_val("irq on", 32'h1, {31'h0, irq});
    wr(ADDR_FLAG, 32'h0);
    check_val("irq cleared", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_ENABLE, 32'h0);
    // Crystal-driven counting: sync, bypass, prescale carry-over and stopped counter.
    ext_run(8'h0B, ADDR_COUNT_LOW, 10, 32'd10);
    // The crystal amplifier must stay powered while the device sleeps.
    strobe(0);
    check_val("osc in sleep", 32'h1, {31'h0, osc_en});
    strobe(1);
    ext_run(8'h0F, ADDR_COUNT_LOW, 10, 32'd10);
    ext_run(8'h1B, ADDR_COUNT_LOW, 9, 32'd4);
    ext_run(8'h1B, ADDR_COUNT_HIGH, 1, 32'd5);
    // Divider is left at 2 here; at 1:4 that passes one tick in two edges, a cleared divider passes none.
    ext_run(8'h2B, ADDR_COUNT_LOW, 2, 32'd0);
    ext_run(8'h1A, ADDR_COUNT_LOW, 4, 32'd0);
    report_and_stop();
  end
endmodule
